// ---- hw/arlt_timer.sv ----
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ns
// Operation
// - Sixteen-bit count in two bytes; split bit gives two 8-bit timers.
// - Clocks: system clock, system clock/12, external/8, low-frequency/8.
// - Divided clocks synchronised to system clock in every mode, suspend included.
// - Timer counts during suspend only from external/8 or low-frequency/8; its overflow wakes the device.
// - After a foreign wake, sync-busy stays set up to three ticks.
// - 16-bit rollover reloads from reload bytes and sets high flag.
// - 16-bit mode interrupts on every full overflow when enabled.
// - 16-bit mode with low enable also interrupts on low rollover.
// - Split halves reload independently from their own reload byte.
// - In split mode run gates only the high half.
// - Half select one picks system clock; else the shared source field.
// - Split mode sets high or low flag on that half's rollover.
// - Split mode interrupts on high overflow; either half with low enable.
// - Hardware never clears the overflow flags; software does.
// - Capture copies count to reload bytes on oscillator falling edge.
// - Control bits sit at 7 down to 0, all reset to zero.
module arlt_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic ext_clk_i,
   input wire logic low_freq_osc_i,
   input wire logic suspend_i,
   input wire logic other_wake_i,
   output logic irq_o,
   output logic wake_o
);
   // ==========================================================
   // Pin synchronisers; stage one feeds stage two only.
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic ext_prev_q;
   logic lfo_prev_q;
   logic susp_prev_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         ext_prev_q <= 1'b0;
         lfo_prev_q <= 1'b0;
         susp_prev_q <= 1'b0;
      end else begin
         s1_q <= {other_wake_i, suspend_i, low_freq_osc_i, ext_clk_i};
         s2_q <= s1_q;
         ext_prev_q <= s2_q[0];
         lfo_prev_q <= s2_q[1];
         susp_prev_q <= s2_q[2];
      end
   end
   wire ext_rise = s2_q[0] & ~ext_prev_q;
   wire lfo_rise = s2_q[1] & ~lfo_prev_q;
   wire lfo_fall = ~s2_q[1] & lfo_prev_q;
   wire suspended = s2_q[2];
   wire wake_other = s2_q[3];

   // ==========================================================
   // Prescalers: each slow rate is a one-cycle enable pulse.
   logic [3:0] div12_q;
   logic [2:0] ext8_q;
   logic [2:0] lfo8_q;
   wire tick12 = (div12_q == arlt_pkg::DIV_SYS - 4'h1);
   wire tick_ext = ext_rise && (ext8_q == arlt_pkg::DIV_SLOW);
   wire tick_lfo = lfo_rise && (lfo8_q == arlt_pkg::DIV_SLOW);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div12_q <= 4'h0;
         ext8_q <= 3'h0;
         lfo8_q <= 3'h0;
      end else begin
         div12_q <= tick12 ? 4'h0 : div12_q + 4'h1;
         if (ext_rise) ext8_q <= ext8_q + 3'h1;
         if (lfo_rise) lfo8_q <= lfo8_q + 3'h1;
      end
   end

   // ==========================================================
   // Registers and tick selection.
   logic [7:0] ctrl_q;
   logic [7:0] rll_q;
   logic [7:0] rlh_q;
   logic [7:0] cntl_q;
   logic [7:0] cnth_q;
   logic [2:0] aux_q;
   logic [1:0] busy_cnt_q;
   wire [1:0] src = ctrl_q[arlt_pkg::CTL_SRC_HI:arlt_pkg::CTL_SRC_LO];
   wire split = ctrl_q[arlt_pkg::CTL_SPLIT];
   wire run = ctrl_q[arlt_pkg::CTL_RUN];
   wire capen = ctrl_q[arlt_pkg::CTL_CAPEN];
   wire lien = ctrl_q[arlt_pkg::CTL_LIEN];
   wire tien = aux_q[arlt_pkg::AUX_TIEN];
   // The divided clocks are edge-synchronised in every mode; in suspend
   // the system clock is assumed to keep the counter logic alive, so the
   // same synchronised tick stands in for the direct drive.
   wire slow_tick = (src == arlt_pkg::SRC_DIV12) ? tick12 :
      (src == arlt_pkg::SRC_EXT8) ? tick_ext :
      (src == arlt_pkg::SRC_LFO) ? tick_lfo : 1'b0;
   // Suspend gates the system-clock sources, so only external sources count.
   wire ext_src = (src == arlt_pkg::SRC_EXT8) || (src == arlt_pkg::SRC_LFO);
   wire slow_ok = suspended ? (slow_tick & ext_src) : slow_tick;
   wire tick_l = aux_q[arlt_pkg::AUX_LSYS] ? ~suspended : slow_ok;
   wire tick_h = split ? (aux_q[arlt_pkg::AUX_HSYS] ? ~suspended : slow_ok)
      : tick_l;
   // 16-bit mode counts as one; split mode runs the low half always.
   wire inc_l = split ? tick_l : (tick_l & run);
   wire inc_h = run & tick_h;
   wire ovf_l = inc_l && (cntl_q == 8'hFF);
   wire ovf_16 = !split && ovf_l && (cnth_q == 8'hFF);
   wire ovf_h = split ? (inc_h && (cnth_q == 8'hFF)) : ovf_16;
   wire cap_ev = capen & lfo_fall;

   // ==========================================================
   // Bus decode; one wait-free answer the cycle after the request.
   wire req = cyc_i & stb_i & ~ack_o;
   wire wr = req & we_i & sel_i[0];
   wire wr_ctrl = wr && (adr_i == arlt_pkg::OFF_CTRL);
   wire wr_rll = wr && (adr_i == arlt_pkg::OFF_RLL);
   wire wr_rlh = wr && (adr_i == arlt_pkg::OFF_RLH);
   wire wr_cntl = wr && (adr_i == arlt_pkg::OFF_CNTL);
   wire wr_cnth = wr && (adr_i == arlt_pkg::OFF_CNTH);
   wire wr_aux = wr && (adr_i == arlt_pkg::OFF_AUX);
   wire busy = (busy_cnt_q != 2'h0);
   wire [7:0] rd_mux = (adr_i == arlt_pkg::OFF_CTRL) ? ctrl_q :
      (adr_i == arlt_pkg::OFF_RLL) ? rll_q :
      (adr_i == arlt_pkg::OFF_RLH) ? rlh_q :
      (adr_i == arlt_pkg::OFF_CNTL) ? cntl_q :
      (adr_i == arlt_pkg::OFF_CNTH) ? cnth_q :
      (adr_i == arlt_pkg::OFF_AUX) ? {5'h00, aux_q} :
      (adr_i == arlt_pkg::OFF_STAT) ? {6'h00, suspended, busy} : 8'h00;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         dat_o <= req ? {24'h000000, rd_mux} : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Control: flags set by hardware win over a software clear.
   wire set_h = ovf_h | cap_ev;
   wire set_l = ovf_l;
   wire [7:0] ctrl_d = wr_ctrl ? dat_i[7:0] : ctrl_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= arlt_pkg::CTRL_RST;
         aux_q <= arlt_pkg::AUX_RST;
      end else begin
         ctrl_q <= ctrl_d;
         if (set_h) ctrl_q[arlt_pkg::CTL_HFLAG] <= 1'b1;
         if (set_l) ctrl_q[arlt_pkg::CTL_LFLAG] <= 1'b1;
         if (wr_aux) aux_q <= dat_i[2:0];
      end
   end

   // ==========================================================
   // Counter halves and reload bytes; a write beats a tick.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cntl_q <= arlt_pkg::BYTE_RST;
         cnth_q <= arlt_pkg::BYTE_RST;
         rll_q <= arlt_pkg::BYTE_RST;
         rlh_q <= arlt_pkg::BYTE_RST;
      end else begin
         if (wr_cntl) cntl_q <= dat_i[7:0];
         else if (ovf_l && (split || ovf_16)) cntl_q <= rll_q;
         else if (inc_l) cntl_q <= cntl_q + 8'h01;
         if (wr_cnth) cnth_q <= dat_i[7:0];
         else if (ovf_h) cnth_q <= rlh_q;
         else if (!split && ovf_l) cnth_q <= cnth_q + 8'h01;
         else if (split && inc_h) cnth_q <= cnth_q + 8'h01;
         if (cap_ev) begin
            rll_q <= cntl_q;
            rlh_q <= cnth_q;
         end else begin
            if (wr_rll) rll_q <= dat_i[7:0];
            if (wr_rlh) rlh_q <= dat_i[7:0];
         end
      end
   end

   // ==========================================================
   // Wake, sync-busy and interrupt outputs.
   wire fast_tick = tick_l | tick_h;
   wire foreign_wake = susp_prev_q & ~suspended & wake_other;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_cnt_q <= 2'h0;
         wake_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         if (foreign_wake) busy_cnt_q <= arlt_pkg::SYNC_TICKS;
         else if (busy && (fast_tick | slow_tick))
            busy_cnt_q <= busy_cnt_q - 2'h1;
         wake_o <= suspended & (ovf_h | ovf_l & split & lien);
         // 16-bit: full overflow, plus low byte with low enable.
         irq_o <= tien & (set_h | (lien & set_l));
      end
   end

   // ==========================================================
   // Checks. One clock domain, so they share a default clock and reset.
   default clocking chk_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // A full 16-bit wrap that no software write disturbs.
   sequence s_full_wrap;
      !split && inc_l && cntl_q == 8'hFF && cnth_q == 8'hFF && !wr_cntl
         && !wr_cnth;
   endsequence
   // After the wrap the count shows the reload bytes and the high flag.
   sequence s_reloaded16;
      cnth_q == $past(rlh_q) && cntl_q == $past(rll_q)
         && ctrl_q[arlt_pkg::CTL_HFLAG];
   endsequence
   // Eleven quiet cycles of the divide-by-12 prescaler between pulses.
   sequence s_div12_gap;
      !tick12 [*8] ##1 !tick12 ##1 !tick12 ##1 !tick12;
   endsequence

   // A clean full wrap reloads both bytes.
   reload16_a: assert property (
      s_full_wrap |=> s_reloaded16)
      else $error("16-bit wrap did not reload");

   // Every full overflow interrupts while the timer enable is set.
   irq16_a: assert property (
      (tien && ovf_16) |=> irq_o)
      else $error("missing overflow irq");

   // Low byte rollover interrupts with both enables set.
   irqlow_a: assert property (
      (tien && lien && ovf_l) |=> irq_o)
      else $error("missing low irq");

   // Without the timer enable no interrupt may leave the block.
   irqmask_a: assert property (
      !tien |=> !irq_o)
      else $error("irq while disabled");

   // Every interrupt pulse follows a flag event.
   irqsrc_a: assert property (
      irq_o |-> $past(set_h || set_l))
      else $error("irq without an event");

   // Split mode interrupts on each high half overflow.
   splitirq_a: assert property (
      (split && tien && ovf_h) |=> irq_o)
      else $error("missing high half irq");

   // Split low half reloads from its own reload byte.
   splitl_a: assert property (
      (split && ovf_l && !wr_cntl) |=> cntl_q == $past(rll_q))
      else $error("low half did not reload");

   // Split high half reloads from its own reload byte.
   splith_a: assert property (
      (split && ovf_h && !wr_cnth) |=> cnth_q == $past(rlh_q))
      else $error("high half did not reload");

   // The split low half counts whatever the run bit says.
   lowrun_a: assert property (
      (split && tick_l && cntl_q != 8'hFF && !wr_cntl)
      |=> cntl_q == $past(cntl_q) + 8'h01) else $error("low half stalled");

   // In 16-bit mode a running low byte steps by one per tick.
   step16_a: assert property (
      (!split && inc_l && cntl_q != 8'hFF && !wr_cntl)
      |=> cntl_q == $past(cntl_q) + 8'h01) else $error("count missed a tick");

   // In 16-bit mode a clear run bit holds the low count byte.
   stop16_a: assert property (
      (!split && !run && !wr_cntl) |=> $stable(cntl_q))
      else $error("stopped count moved");

   // A stopped high half holds its value.
   hold_a: assert property (
      (split && !run && !wr_cnth) |=> $stable(cnth_q))
      else $error("stopped high half moved");

   // A low byte overflow always raises the low flag.
   lflag_a: assert property (
      ovf_l |=> ctrl_q[arlt_pkg::CTL_LFLAG])
      else $error("low flag not set");

   // A split high half overflow raises the high flag.
   hflag_a: assert property (
      (split && ovf_h) |=> ctrl_q[arlt_pkg::CTL_HFLAG])
      else $error("high flag not set");

   // Only a software write may clear the low flag.
   flagkeep_a: assert property (
      (ctrl_q[arlt_pkg::CTL_LFLAG] && !wr_ctrl)
      |=> ctrl_q[arlt_pkg::CTL_LFLAG]) else $error("low flag lost");

   // Only a software write may clear the high flag.
   hflagkeep_a: assert property (
      (ctrl_q[arlt_pkg::CTL_HFLAG] && !wr_ctrl)
      |=> ctrl_q[arlt_pkg::CTL_HFLAG]) else $error("high flag lost");

   // A capture copies both count bytes and raises the high flag.
   capture_a: assert property (
      cap_ev |=> rll_q == $past(cntl_q) && rlh_q == $past(cnth_q)
      && ctrl_q[arlt_pkg::CTL_HFLAG]) else $error("capture did not copy");

   // A foreign wake raises sync-busy the cycle after.
   busy_a: assert property (
      foreign_wake |=> busy)
      else $error("sync busy not raised");

   // Sync-busy counts down one step per timer tick.
   busystep_a: assert property (
      (busy && !foreign_wake && (fast_tick || slow_tick))
      |=> busy_cnt_q == $past(busy_cnt_q) - 2'h1) else $error("busy step");

   // Without a tick the sync-busy span does not shrink.
   busyhold_a: assert property (
      (busy && !foreign_wake && !fast_tick && !slow_tick)
      |=> busy_cnt_q == $past(busy_cnt_q)) else $error("busy moved");

   // A high half or full 16-bit overflow while suspended wakes the device.
   wake_a: assert property (
      (suspended && ovf_h) |=> wake_o)
      else $error("overflow did not wake");

   // No wake pulse while the device is awake.
   nowake_a: assert property (
      !suspended |=> !wake_o)
      else $error("wake while awake");

   // The divide-by-12 prescaler pulses once every twelve clocks.
   div12_a: assert property (
      tick12 |=> s_div12_gap ##1 tick12)
      else $error("divide by 12 spacing");

   // A taken request is answered once, the cycle after.
   ack_a: assert property (
      req |=> ack_o ##1 !ack_o)
      else $error("bus answer wrong");

   // Leaving reset, control is zero and every output is quiet.
   resetz_a: assert property (
      $fell(rst_i) |-> ctrl_q == 8'h00 && !irq_o && !wake_o && !ack_o)
      else $error("not clean after reset");
endmodule

// ---- inc/arlt_pkg.sv ----
package arlt_pkg;
   // ==========================================================
   // Register offsets (byte addresses, one word each).
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_RLL = 8'h04;
   localparam logic [7:0] OFF_RLH = 8'h08;
   localparam logic [7:0] OFF_CNTL = 8'h0C;
   localparam logic [7:0] OFF_CNTH = 8'h10;
   localparam logic [7:0] OFF_AUX = 8'h14;
   localparam logic [7:0] OFF_STAT = 8'h18;
   // ==========================================================
   // Control register field positions.
   localparam int CTL_HFLAG = 7;
   localparam int CTL_LFLAG = 6;
   localparam int CTL_LIEN = 5;
   localparam int CTL_CAPEN = 4;
   localparam int CTL_SPLIT = 3;
   localparam int CTL_RUN = 2;
   localparam int CTL_SRC_HI = 1;
   localparam int CTL_SRC_LO = 0;
   // Auxiliary register fields: interrupt enable and half selects.
   localparam int AUX_TIEN = 0;
   localparam int AUX_LSYS = 1;
   localparam int AUX_HSYS = 2;
   // Status register fields.
   localparam int STA_BUSY = 0;
   localparam int STA_SUSP = 1;
   // ==========================================================
   // Reset values and clock source encodings.
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [2:0] AUX_RST = 3'h0;
   localparam logic [1:0] SRC_DIV12 = 2'h0;
   localparam logic [1:0] SRC_EXT8 = 2'h1;
   localparam logic [1:0] SRC_LFO = 2'h3;
   // ==========================================================
   // Divider counts and the wake synchronisation span in ticks.
   localparam logic [3:0] DIV_SYS = 4'hC;
   localparam logic [2:0] DIV_SLOW = 3'h7;
   localparam logic [1:0] SYNC_TICKS = 2'h3;
endpackage

// ---- tb/tb_auto_reload_timer_lfo_capture.sv ----
`timescale 1ns/1ns
module tb_auto_reload_timer_lfo_capture;
   // ==========================================================
   // Stimulus signals and counters.
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic ack_o, irq_o, wake_o;
   logic ext_clk_i = 1'b0, low_freq_osc_i = 1'b0;
   logic suspend_i = 1'b0, other_wake_i = 1'b0;
   logic [1:0] ediv = 2'h0;
   logic [7:0] r;
   int n_errors = 0, checked = 0, cycles = 0;
   bit seen;
   arlt_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .ext_clk_i(ext_clk_i), .low_freq_osc_i(low_freq_osc_i),
      .suspend_i(suspend_i), .other_wake_i(other_wake_i),
      .irq_o(irq_o), .wake_o(wake_o));
   // 10 MHz clock; the external pin toggles every two cycles.
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      ediv <= ediv + 2'h1;
      ext_clk_i <= ediv[1];
   end
   // Hang guard; the whole run needs well under 5000 cycles.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail("timeout");
         summarize();
      end
   end
   // ==========================================================
   // Shared tasks.
   task automatic summarize();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic fail(input string m);
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   // Classic cycle: hold everything until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w;
      adr_i <= a; dat_i <= {24'h0, d}; sel_i <= 4'h1;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      if (n == 40) fail("no ack");
      r = dat_o[7:0];
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      checked++;
      if ((r & m) !== e) fail("read value mismatch");
   endtask
   task automatic wt(input bit w, input int lim);
      seen = 0;
      for (int n = 0; n < lim && !seen; n++) begin
         @(posedge clk_i);
         if (((w) ? wake_o : irq_o) === 1'b1) seen = 1;
      end
   endtask
   task automatic expect_seen(input bit e);
      checked++;
      if (seen !== e) fail("pulse mismatch");
   endtask
   // Loads control, counts and reloads; stop first so nothing moves.
   task automatic setup(input logic [7:0] aux, cl, ch, ll, lh);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h00);
      wb(1'b1, arlt_pkg::OFF_AUX, aux);
      wb(1'b1, arlt_pkg::OFF_CNTL, cl);
      wb(1'b1, arlt_pkg::OFF_CNTH, ch);
      wb(1'b1, arlt_pkg::OFF_RLL, ll);
      wb(1'b1, arlt_pkg::OFF_RLH, lh);
   endtask
   // ==========================================================
   // Scenarios.
   task automatic s_reset();
      for (int a = 0; a <= 'h1C; a += 4) rd(a[7:0], 8'hFF, 8'h00);
      wb(1'b1, 8'h1C, 8'hA5);
      rd(8'h1C, 8'hFF, 8'h00);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h3B);
      rd(arlt_pkg::OFF_CTRL, 8'hFF, 8'h3B);
   endtask
   task automatic s_full();
      setup(8'h07, 8'hFE, 8'hFF, 8'h34, 8'h12);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h04);
      wt(0, 30);
      expect_seen(1);
      rd(arlt_pkg::OFF_CTRL, 8'hFF, 8'hC4);
      rd(arlt_pkg::OFF_CNTH, 8'hFF, 8'h12);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h00);
      rd(arlt_pkg::OFF_CTRL, 8'hFF, 8'h00);
   endtask
   task automatic s_low();
      for (int e = 0; e < 2; e++) begin
         setup(8'h07, 8'hFE, 8'h00, 8'h00, 8'h00);
         wb(1'b1, arlt_pkg::OFF_CTRL, {2'b00, e[0], 5'h04});
         wt(0, 30);
         expect_seen(e[0]);
         rd(arlt_pkg::OFF_CTRL, 8'hC0, 8'h40);
      end
   endtask
   task automatic s_split();
      setup(8'h07, 8'hF0, 8'h77, 8'hA0, 8'h11);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h28);
      wt(0, 40);
      expect_seen(1);
      rd(arlt_pkg::OFF_CTRL, 8'hFF, 8'h68);
      rd(arlt_pkg::OFF_CNTH, 8'hFF, 8'h77);
      rd(arlt_pkg::OFF_CNTL, 8'hE0, 8'hA0);
      wb(1'b1, arlt_pkg::OFF_CNTH, 8'hFE);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h0C);
      wt(0, 30);
      expect_seen(1);
      rd(arlt_pkg::OFF_CTRL, 8'hBF, 8'h8C);
      rd(arlt_pkg::OFF_CNTH, 8'hE0, 8'h00);
   endtask
   task automatic s_capture();
      setup(8'h07, 8'h00, 8'h55, 8'h00, 8'h00);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h14);
      low_freq_osc_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      low_freq_osc_i <= 1'b0;
      wt(0, 30);
      expect_seen(1);
      rd(arlt_pkg::OFF_RLH, 8'hFF, 8'h55);
      rd(arlt_pkg::OFF_CTRL, 8'h80, 8'h80);
   endtask
   task automatic s_div12();
      setup(8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h04);
      repeat (120) @(posedge clk_i);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h00);
      wb(1'b0, arlt_pkg::OFF_CNTL, 8'h00);
      checked++;
      if ($isunknown(r) || r < 8'h09 || r > 8'h0C)
         fail("divide by 12 rate");
   endtask
   task automatic s_suspend();
      setup(8'h01, 8'hFD, 8'hFF, 8'h00, 8'h00);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h05);
      suspend_i <= 1'b1;
      wt(1, 400);
      expect_seen(1);
      other_wake_i <= 1'b1;
      suspend_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(arlt_pkg::OFF_STAT, 8'h01, 8'h01);
      repeat (300) @(posedge clk_i);
      other_wake_i <= 1'b0;
      rd(arlt_pkg::OFF_STAT, 8'h01, 8'h00);
   endtask
   // Reset in mid-run, then count sixteen oscillator rises as two ticks.
   task automatic s_lfo();
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(arlt_pkg::OFF_CTRL, 8'hFF, 8'h00);
      rd(arlt_pkg::OFF_AUX, 8'hFF, 8'h00);
      wb(1'b1, arlt_pkg::OFF_AUX, 8'h01);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h07);
      // The pin is the oscillator with its own divider left at one.
      repeat (32) begin
         @(posedge clk_i);
         low_freq_osc_i <= ~low_freq_osc_i;
      end
      repeat (6) @(posedge clk_i);
      wb(1'b1, arlt_pkg::OFF_CTRL, 8'h00);
      rd(arlt_pkg::OFF_CNTL, 8'hFF, 8'h02);
   endtask
   // ==========================================================
   // Main sequence.
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      s_reset();
      s_full();
      s_low();
      s_split();
      s_capture();
      s_div12();
      s_suspend();
      s_lfo();
      summarize();
   end
endmodule
